// *** rtl/pin_boot_config.sv ***
// Purpose: Boot configured pin pair with crystal oscillator control.
// Assumes: All request inputs except pads, the 32 kHz clock and crystal valid are core_clk logic.
// Notes:   Read data appear one cycle after the read strobe.
// Functional notes
// - First pin function field selects by direction.
// - Codes 8..11: scaling done, external enables.
// - Codes 12, 13: supply good, power good.
// - Code 14 two MHz clock, 15 reset.
// - Crystal enable gates oscillator in off/on/sleep.
// - Backup state uses the backup enable.
// - Crystal enable writable only during config load.
// - Inhibit clear: RC clock until crystal valid.
// - Inhibit set: on transition waits for crystal.
// - Second pin enable tristates; direction bit selects.
// - Pull field: none, down, up, reserved.
// - Single edge mode follows polarity.
// - Both edges mode ignores polarity.
// - Supply domain bit selects pin supply.
// - Polarity bit inverts pin when clear.
// - Output type: push-pull or open drain.
`timescale 1ns/1ns
`default_nettype none

module pin_port
	import pinboot_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    rstn,
	input  wire pinboot_pkg::pin_cfg_t   cfg,
	input  wire logic                    out_value,
	input  wire logic                    pad_in,
	output pinboot_pkg::pin_drive_t      drive,
	output logic                         in_level,
	output logic                         edge_pulse
);
	logic pad_s1_q;
	logic pad_s2_q;
	logic pad_prev_q;
	logic lvl_now;
	logic lvl_prev;
	logic active_input;
	logic drv_value;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pad_s1_q   <= 1'b0;
			pad_s2_q   <= 1'b0;
			pad_prev_q <= 1'b0;
		end else begin
			pad_s1_q   <= pad_in;
			pad_s2_q   <= pad_s1_q;
			pad_prev_q <= pad_s2_q;
		end
	end

	// Polarity is folded in so the single edge case is always a rising edge.
	assign lvl_now      = pad_s2_q ^ ~cfg.polarity_high;
	assign lvl_prev     = pad_prev_q ^ ~cfg.polarity_high;
	assign in_level     = lvl_now;
	assign active_input = cfg.enable && cfg.dir_input;
	assign drv_value    = out_value ^ ~cfg.polarity_high;

	always_comb begin
		edge_pulse = 1'b0;
		if (active_input) begin
			if (cfg.irq_both_edges) begin
				edge_pulse = lvl_now != lvl_prev;
			end else begin
				edge_pulse = lvl_now && !lvl_prev;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			drive <= '0;
		end else begin
			drive.pull_up    <= cfg.pull == PULL_UP;
			drive.pull_down  <= cfg.pull == PULL_DOWN;
			drive.supply_sel <= cfg.supply_sel;
			if (!cfg.enable || cfg.dir_input) begin
				drive.oe  <= 1'b0;
				drive.out <= 1'b0;
			end else if (cfg.open_drain) begin
				drive.oe  <= !drv_value;
				drive.out <= 1'b0;
			end else begin
				drive.oe  <= 1'b1;
				drive.out <= drv_value;
			end
		end
	end
endmodule

module pin_boot_config
	import pinboot_pkg::*;
(
	input  wire logic                         core_clk,
	input  wire logic                         rstn,
	input  wire logic [pinboot_pkg::ADDR_W-1:0] addr,
	input  wire logic [pinboot_pkg::DATA_W-1:0] wdata,
	input  wire logic                         wr_en,
	input  wire logic                         rd_en,
	output logic [pinboot_pkg::DATA_W-1:0]    rdata,
	input  wire logic                         config_load,
	input  wire pinboot_pkg::pwr_state_t      power_state,
	input  wire logic                         crystal_backup_enable,
	input  wire logic                         crystal_valid,
	input  wire logic                         on_request,
	output logic                              on_permit,
	output logic                              crystal_osc_enable,
	output logic                              clock_output_from_rc,
	input  wire logic                         osc32k_clk,
	input  wire logic                         on_state,
	input  wire logic                         sleep_state,
	input  wire logic                         state_change,
	input  wire logic                         dvs1_done,
	input  wire logic                         dvs2_done,
	input  wire logic                         ext_pwr_en1,
	input  wire logic                         ext_pwr_en2,
	input  wire logic                         system_supply_good,
	input  wire logic                         converter_power_good,
	input  wire logic                         aux_reset,
	output logic [3:0]                        pin1_input_function,
	output logic                              pin1_input_level,
	output logic                              pin2_input_level,
	input  wire logic                         pin1_pad_in,
	output pinboot_pkg::pin_drive_t           pin1_drive,
	input  wire logic                         pin2_pad_in,
	output pinboot_pkg::pin_drive_t           pin2_drive,
	output logic                              irq
);
	import pinboot_pkg::*;

	pin_cfg_t         pin1_cfg_q;
	pin_cfg_t         pin2_cfg_q;
	logic [3:0]       pin1_fn_q;
	logic             crystal_osc_enable_q;
	logic             crystal_startup_inhibit_q;
	logic             pin1_out_q;
	logic             pin2_out_q;
	logic [IRQ_W-1:0] irq_status_q;
	logic [IRQ_W-1:0] irq_status_d;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic             xv_s1_q;
	logic             xv_s2_q;
	logic             xv_prev_q;
	logic             o32_s1_q;
	logic             o32_s2_q;
	logic [2:0]       ext_div_q;
	logic             ext_clk_q;
	logic             pin1_src;
	logic             pin1_edge;
	logic             pin2_edge;
	logic             wr_pin1;
	logic             wr_pin2;

	assign wr_pin1 = wr_en && addr == PIN1_BOOT_CONFIG_ADDR;
	assign wr_pin2 = wr_en && addr == PIN2_BOOT_CONFIG_ADDR;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin1_cfg_q <= PIN_CFG_RST;
			pin1_fn_q  <= FN_RST;
			crystal_startup_inhibit_q <= 1'b0;
		end else if (wr_pin1) begin
			pin1_cfg_q <= wdata[CFG_LSB +: 8];
			pin1_fn_q  <= wdata[FN_LSB +: 4];
			crystal_startup_inhibit_q <= wdata[CRYSTAL_STARTUP_INHIBIT_BIT];
		end
	end

	// The crystal enable is fixed once boot loading is over.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			crystal_osc_enable_q <= 1'b0;
		end else if (wr_pin1 && config_load) begin
			crystal_osc_enable_q <= wdata[CRYSTAL_OSC_ENABLE_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin2_cfg_q <= PIN_CFG_RST;
		end else if (wr_pin2) begin
			pin2_cfg_q <= wdata[CFG_LSB +: 8];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin1_out_q <= 1'b0;
			pin2_out_q <= 1'b0;
		end else if (wr_en && addr == PIN_DATA_ADDR) begin
			pin1_out_q <= wdata[PIN1_OUT_BIT];
			pin2_out_q <= wdata[PIN2_OUT_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_mask_q <= '0;
		end else if (wr_en && addr == IRQ_MASK_ADDR) begin
			irq_mask_q <= wdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			xv_s1_q   <= 1'b0;
			xv_s2_q   <= 1'b0;
			xv_prev_q <= 1'b0;
			o32_s1_q  <= 1'b0;
			o32_s2_q  <= 1'b0;
		end else begin
			xv_s1_q   <= crystal_valid;
			xv_s2_q   <= xv_s1_q;
			xv_prev_q <= xv_s2_q;
			o32_s1_q  <= osc32k_clk;
			o32_s2_q  <= o32_s1_q;
		end
	end

	// Divide by five gives 2 MHz; the duty cycle is two fifths high.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ext_div_q <= '0;
			ext_clk_q <= 1'b0;
		end else begin
			ext_div_q <= (ext_div_q == EXT_DIV_LAST) ? 3'h0 : ext_div_q + 3'h1;
			ext_clk_q <= ext_div_q < EXT_DIV_HIGH;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			crystal_osc_enable   <= 1'b0;
			clock_output_from_rc <= 1'b1;
			on_permit            <= 1'b0;
		end else begin
			if (power_state == PS_BACKUP) begin
				crystal_osc_enable <= crystal_backup_enable;
			end else begin
				crystal_osc_enable <= crystal_osc_enable_q;
			end
			clock_output_from_rc <= !xv_s2_q;
			on_permit            <= on_request && (!crystal_startup_inhibit_q || xv_s2_q);
		end
	end

	// Reserved output codes select a constant low source.
	always_comb begin
		case (pin1_fn_q)
			FN_GPIO_OUT:    pin1_src = pin1_out_q;
			FN_OSC32K:      pin1_src = o32_s2_q;
			FN_ON_STATE:    pin1_src = on_state;
			FN_SLEEP_STATE: pin1_src = sleep_state;
			FN_STATE_CHG:   pin1_src = state_change;
			FN_DVS1_DONE:   pin1_src = dvs1_done;
			FN_DVS2_DONE:   pin1_src = dvs2_done;
			FN_EXT_PWR_EN1: pin1_src = ext_pwr_en1;
			FN_EXT_PWR_EN2: pin1_src = ext_pwr_en2;
			FN_SYS_GOOD:    pin1_src = system_supply_good;
			FN_CONVERTER_POWER_GOOD:    pin1_src = converter_power_good;
			FN_EXT_CLK:     pin1_src = ext_clk_q;
			FN_AUX_RESET:   pin1_src = aux_reset;
			default:        pin1_src = 1'b0;
		endcase
	end

	// In input direction the code is handed to the input function decoders.
	assign pin1_input_function = pin1_cfg_q.dir_input ? pin1_fn_q : FN_RST;

	pin_port u_pin1 (
		.core_clk   (core_clk),
		.rstn       (rstn),
		.cfg        (pin1_cfg_q),
		.out_value  (pin1_src),
		.pad_in     (pin1_pad_in),
		.drive      (pin1_drive),
		.in_level   (pin1_input_level),
		.edge_pulse (pin1_edge)
	);

	pin_port u_pin2 (
		.core_clk   (core_clk),
		.rstn       (rstn),
		.cfg        (pin2_cfg_q),
		.out_value  (pin2_out_q),
		.pad_in     (pin2_pad_in),
		.drive      (pin2_drive),
		.in_level   (pin2_input_level),
		.edge_pulse (pin2_edge)
	);

	// A new event in the clearing cycle survives the clear.
	always_comb begin
		irq_set               = '0;
		irq_set[IRQ_PIN1_BIT] = pin1_edge;
		irq_set[IRQ_PIN2_BIT] = pin2_edge;
		irq_set[IRQ_XTAL_BIT] = xv_s2_q && !xv_prev_q;
		irq_clr               = '0;
		if (wr_en && addr == IRQ_STATUS_ADDR) begin
			irq_clr = wdata[IRQ_W-1:0];
		end
		irq_status_d = (irq_status_q & ~irq_clr) | irq_set;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= irq_status_d;
		end
	end

	assign irq = |(irq_status_q & irq_mask_q);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= '0;
		end else if (rd_en) begin
			if (addr == PIN1_BOOT_CONFIG_ADDR) begin
				rdata <= {pin1_cfg_q, pin1_fn_q, 1'b0, crystal_osc_enable_q, crystal_startup_inhibit_q, 1'b0};
			end else if (addr == PIN2_BOOT_CONFIG_ADDR) begin
				rdata <= {pin2_cfg_q, 8'h00};
			end else if (addr == IRQ_STATUS_ADDR) begin
				rdata <= {13'h0000, irq_status_q};
			end else if (addr == IRQ_MASK_ADDR) begin
				rdata <= {13'h0000, irq_mask_q};
			end else if (addr == PIN_DATA_ADDR) begin
				rdata <= {6'h00, pin2_input_level, pin1_input_level,
					6'h00, pin2_out_q, pin1_out_q};
			end else begin
				rdata <= '0;
			end
		end else begin
			rdata <= '0;
		end
	end

	// Helper: an output pin driving non-inverted push-pull.
	logic pin1_plain_out;
	assign pin1_plain_out = pin1_cfg_q.enable && !pin1_cfg_q.dir_input &&
		pin1_cfg_q.polarity_high && !pin1_cfg_q.open_drain;

	a_fn_dvs_done: assert property (@(posedge core_clk) disable iff (!rstn)
		pin1_plain_out && pin1_fn_q == FN_DVS1_DONE |=> pin1_drive.out == $past(dvs1_done))
		else $error("Pin one does not show converter one scaling done.");

	a_fn_supply_good: assert property (@(posedge core_clk) disable iff (!rstn)
		pin1_plain_out && pin1_fn_q == FN_SYS_GOOD |=> pin1_drive.out == $past(system_supply_good))
		else $error("Pin one does not show system supply good.");

	a_fn_ext_clock: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(ext_clk_q) |=> ext_clk_q ##1 !ext_clk_q [*3] ##1 ext_clk_q)
		else $error("External power clock period is not five core cycles.");

	a_crystal_enable: assert property (@(posedge core_clk) disable iff (!rstn)
		power_state != PS_BACKUP |=> crystal_osc_enable == $past(crystal_osc_enable_q))
		else $error("Crystal enable does not follow its config bit.");

	a_crystal_backup: assert property (@(posedge core_clk) disable iff (!rstn)
		power_state == PS_BACKUP |=> crystal_osc_enable == $past(crystal_backup_enable))
		else $error("Backup crystal enable is not honoured.");

	a_crystal_lock: assert property (@(posedge core_clk) disable iff (!rstn)
		!config_load |=> $stable(crystal_osc_enable_q))
		else $error("Crystal enable changed outside config loading.");

	a_rc_until_valid: assert property (@(posedge core_clk) disable iff (!rstn)
		!crystal_valid [*3] |=> clock_output_from_rc)
		else $error("Clock output left the RC source before crystal valid.");

	a_on_inhibit: assert property (@(posedge core_clk) disable iff (!rstn)
		crystal_startup_inhibit_q && !xv_s2_q |=> !on_permit)
		else $error("On transition permitted before crystal valid.");

	a_pin_tristate: assert property (@(posedge core_clk) disable iff (!rstn)
		!pin2_cfg_q.enable || pin2_cfg_q.dir_input |=> !pin2_drive.oe)
		else $error("Disabled or input pin two is driven.");

	a_open_drain: assert property (@(posedge core_clk) disable iff (!rstn)
		pin2_cfg_q.open_drain && !pin2_cfg_q.dir_input |=> !pin2_drive.out)
		else $error("Open drain pin two drives high.");

	a_pull_decode: assert property (@(posedge core_clk) disable iff (!rstn)
		pin2_cfg_q.pull == PULL_NONE |=> !pin2_drive.pull_up && !pin2_drive.pull_down)
		else $error("Pull resistor enabled with no pull selected.");

	a_irq_sticky: assert property (@(posedge core_clk) disable iff (!rstn)
		pin2_edge |=> irq_status_q[IRQ_PIN2_BIT] ##1 irq_status_q[IRQ_PIN2_BIT] ||
			$past(wr_en && addr == IRQ_STATUS_ADDR))
		else $error("Pin two edge flag not latched.");

endmodule

`default_nettype wire

// *** rtl/pinboot_pkg.sv ***
// Purpose: Shared constants and types for the boot pin and crystal control block.
// Assumes: Register words are 16 bits wide and sit at their printed offsets.
// Notes:   Status, mask and pin data registers sit at offsets of our own.
package pinboot_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;

	localparam logic [15:0] PIN1_BOOT_CONFIG_ADDR = 16'h781A;
	localparam logic [15:0] PIN2_BOOT_CONFIG_ADDR = 16'h781B;
	localparam logic [15:0] IRQ_STATUS_ADDR       = 16'h7810;
	localparam logic [15:0] IRQ_MASK_ADDR         = 16'h7811;
	localparam logic [15:0] PIN_DATA_ADDR         = 16'h7812;

	// Field positions inside a boot config word.
	localparam int CFG_LSB      = 8;
	localparam int FN_LSB       = 4;
	localparam int CRYSTAL_OSC_ENABLE_BIT = 2;
	localparam int CRYSTAL_STARTUP_INHIBIT_BIT = 1;

	// Pin data register: output values low, synchronised input levels high.
	localparam int PIN1_OUT_BIT = 0;
	localparam int PIN2_OUT_BIT = 1;
	localparam int PIN1_IN_BIT  = 8;
	localparam int PIN2_IN_BIT  = 9;

	// Interrupt status and mask layout.
	localparam int IRQ_W        = 3;
	localparam int IRQ_PIN1_BIT = 0;
	localparam int IRQ_PIN2_BIT = 1;
	localparam int IRQ_XTAL_BIT = 2;

	// Pin configuration, the upper byte of a boot config word.
	typedef struct packed {
		logic       dir_input;
		logic [1:0] pull;
		logic       irq_both_edges;
		logic       supply_sel;
		logic       polarity_high;
		logic       open_drain;
		logic       enable;
	} pin_cfg_t;

	localparam pin_cfg_t PIN_CFG_RST = 8'hA4;
	localparam logic [3:0] FN_RST    = 4'h0;
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP   = 2'h2;

	// Pad-facing drive signals of one pin.
	typedef struct packed {
		logic out;
		logic oe;
		logic pull_up;
		logic pull_down;
		logic supply_sel;
	} pin_drive_t;

	// Output function codes of the first pin.
	localparam logic [3:0] FN_GPIO_OUT    = 4'h0;
	localparam logic [3:0] FN_OSC32K      = 4'h1;
	localparam logic [3:0] FN_ON_STATE    = 4'h2;
	localparam logic [3:0] FN_SLEEP_STATE = 4'h3;
	localparam logic [3:0] FN_STATE_CHG   = 4'h4;
	localparam logic [3:0] FN_DVS1_DONE   = 4'h8;
	localparam logic [3:0] FN_DVS2_DONE   = 4'h9;
	localparam logic [3:0] FN_EXT_PWR_EN1 = 4'hA;
	localparam logic [3:0] FN_EXT_PWR_EN2 = 4'hB;
	localparam logic [3:0] FN_SYS_GOOD    = 4'hC;
	localparam logic [3:0] FN_CONVERTER_POWER_GOOD    = 4'hD;
	localparam logic [3:0] FN_EXT_CLK     = 4'hE;
	localparam logic [3:0] FN_AUX_RESET   = 4'hF;

	typedef enum logic [1:0] {
		PS_OFF,
		PS_ON,
		PS_SLEEP,
		PS_BACKUP
	} pwr_state_t;

	// External power clock derived from the core clock.
	localparam int CORE_CLK_HZ  = 10_000_000;
	localparam int EXT_CLK_HZ   = 2_000_000;
	localparam int EXT_CLK_DIV  = CORE_CLK_HZ / EXT_CLK_HZ;
	localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_CLK_DIV - 1);
	localparam logic [2:0] EXT_DIV_HIGH = 3'(EXT_CLK_DIV / 2);

endpackage

// *** tb/pin_far_side.sv ***
// Purpose: Far side of the block: two pads with outside drivers and a crystal oscillator.
// Assumes: A pad that nobody drives and no pull holds changes level every cycle.
// Notes:   The crystal reports valid a fixed count of cycles after it is enabled.
`timescale 1ns/1ns
`default_nettype none
module pin_far_side
	import pinboot_pkg::*;
#(
	parameter int XTAL_START = 20
)(
	input  wire logic                    core_clk,
	input  wire pinboot_pkg::pin_drive_t pin1_drive,
	input  wire pinboot_pkg::pin_drive_t pin2_drive,
	input  wire logic [1:0]              ext_oe,
	input  wire logic [1:0]              ext_val,
	input  wire logic                    crystal_osc_enable,
	output logic                         pin1_pad,
	output logic                         pin2_pad,
	output logic                         crystal_valid
);
	pin_drive_t drv [2];
	bit [1:0]   pad_q;
	logic [1:0] pad_d;
	int         xtal_cnt_q;
	assign drv[0] = pin1_drive;
	assign drv[1] = pin2_drive;
	// A floating pad toggles so that a stale level is never mistaken for a driven one.
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (drv[i].oe)
				pad_d[i] = drv[i].out;
			else if (ext_oe[i])
				pad_d[i] = ext_val[i];
			else if (drv[i].pull_up)
				pad_d[i] = 1'b1;
			else if (drv[i].pull_down)
				pad_d[i] = 1'b0;
			else
				pad_d[i] = ~pad_q[i];
		end
	end
	assign pin1_pad = pad_d[0];
	assign pin2_pad = pad_d[1];
	always_ff @(posedge core_clk) begin
		pad_q <= pad_d;
		if (!crystal_osc_enable)
			xtal_cnt_q <= 0;
		else if (xtal_cnt_q < XTAL_START)
			xtal_cnt_q <= xtal_cnt_q + 1;
	end
	assign crystal_valid = (xtal_cnt_q == XTAL_START);
endmodule
`default_nettype wire

// *** tb/pin_boot_config_test.sv ***
// Purpose: Self-checking bench for the boot pin and crystal control block.
// Assumes: Pads and crystal come from the far side model.
// Notes:   Inputs change only by non-blocking assignment after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module pin_boot_config_test;
	import pinboot_pkg::*;
	logic        rstn, wr_en, rd_en, config_load, crystal_backup_enable, core_clk;
	logic        crystal_valid, on_request, on_permit, crystal_osc_enable, prev;
	logic        clock_output_from_rc, irq, pin1_pad, pin2_pad, p1_lvl, p2_lvl;
	logic [15:0] addr, wdata, rdata, rd_val, src;
	logic [3:0]  in_fn;
	logic [1:0]  ext_oe, ext_val;
	pwr_state_t  power_state;
	pin_drive_t  pin1_drive, pin2_drive, e;
	int          err_total, samples_checked, n, hi, rises;
	logic [7:0]  dcfg [6] = '{8'h05, 8'h01, 8'h2F, 8'h43, 8'h64, 8'hA4};
	logic [10:0] et [7] = '{11'h52B, 11'h52C, 11'h50D, 11'h50A, 11'h58B, 11'h5AD, 11'h522};
	pwr_state_t  st [4] = '{PS_SLEEP, PS_BACKUP, PS_BACKUP, PS_ON};

	pin_boot_config uut (
		.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .config_load(config_load), .power_state(power_state),
		.crystal_backup_enable(crystal_backup_enable), .crystal_valid(crystal_valid),
		.on_request(on_request), .on_permit(on_permit), .crystal_osc_enable(crystal_osc_enable),
		.clock_output_from_rc(clock_output_from_rc), .osc32k_clk(src[1]), .on_state(src[2]),
		.sleep_state(src[3]), .state_change(src[4]), .dvs1_done(src[8]), .dvs2_done(src[9]),
		.ext_pwr_en1(src[10]), .ext_pwr_en2(src[11]), .system_supply_good(src[12]),
		.converter_power_good(src[13]), .aux_reset(src[15]), .pin1_input_function(in_fn),
		.pin1_input_level(p1_lvl), .pin2_input_level(p2_lvl), .pin1_pad_in(pin1_pad),
		.pin1_drive(pin1_drive), .pin2_pad_in(pin2_pad), .pin2_drive(pin2_drive), .irq(irq));

	pin_far_side #(.XTAL_START(20)) far (
		.core_clk(core_clk), .pin1_drive(pin1_drive), .pin2_drive(pin2_drive), .ext_oe(ext_oe),
		.ext_val(ext_val), .crystal_osc_enable(crystal_osc_enable), .pin1_pad(pin1_pad),
		.pin2_pad(pin2_pad), .crystal_valid(crystal_valid));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#10;
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic cl = 1'b0);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		config_load <= cl;
		@(posedge core_clk);
		wr_en <= 1'b0;
		config_load <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
	task automatic rd(input logic [15:0] a);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		@(negedge core_clk);
		rd_val = rdata;
	endtask

	function automatic pin_drive_t exp_drive(input pin_cfg_t c, input logic v);
		logic lvl;
		lvl = v ^ ~c.polarity_high;
		exp_drive.out = c.open_drain ? 1'b0 : lvl;
		exp_drive.oe = c.enable & ~c.dir_input & (~c.open_drain | ~lvl);
		exp_drive.pull_up = (c.pull == PULL_UP);
		exp_drive.pull_down = (c.pull == PULL_DOWN);
		exp_drive.supply_sel = c.supply_sel;
	endfunction

	task automatic complete_run;
		$display("Comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#3_000_000;
		$display("Error run time expected finish seen hang");
		err_total++;
		complete_run();
	end

	initial begin
		rstn = 1'b0;
		{wr_en, rd_en, config_load, crystal_backup_enable} = 4'h0;
		addr = 16'h0000;
		wdata = 16'h0000;
		src = 16'h0000;
		on_request = 1'b1;
		power_state = PS_OFF;
		ext_oe = 2'b00;
		ext_val = 2'b00;
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		rd(PIN1_BOOT_CONFIG_ADDR);
		chk("pin1 cfg reset", 16'hA400, rd_val);
		rd(PIN2_BOOT_CONFIG_ADDR);
		chk("pin2 cfg reset", 16'hA400, rd_val);
		rd(16'h7820);
		chk("unmapped read", 16'h0000, rd_val);
		// Crystal still off, so the inhibit must hold the on transition back.
		wr(PIN1_BOOT_CONFIG_ADDR, 16'hA402);
		cyc(2);
		chk("on_permit inhibited", 0, on_permit);
		chk("rc clock", 1, clock_output_from_rc);
		chk("xtal enable off", 0, crystal_osc_enable);
		wr(PIN1_BOOT_CONFIG_ADDR, 16'hA406);
		rd(PIN1_BOOT_CONFIG_ADDR);
		chk("xtal bit locked", 16'hA402, rd_val);
		wr(PIN1_BOOT_CONFIG_ADDR, 16'hA406, 1'b1);
		rd(PIN1_BOOT_CONFIG_ADDR);
		chk("xtal bit loaded", 16'hA406, rd_val);
		chk("xtal enable on", 1, crystal_osc_enable);
		chk("rc before valid", 1, clock_output_from_rc);
		chk("on_permit waits", 0, on_permit);
		n = 0;
		while (on_permit !== 1'b1 && n < 60) begin
			cyc(1);
			n++;
		end
		if (n == 60) begin
			$display("Error on_permit expected 1 seen %b", on_permit);
			err_total++;
			complete_run();
		end
		chk("rc after valid", 0, clock_output_from_rc);
		// Both pins are still disabled, so only the crystal valid flag may be set.
		rd(IRQ_STATUS_ADDR);
		chk("xtal valid flag", 16'h0004, rd_val);
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			power_state <= st[i];
			crystal_backup_enable <= (i == 2);
			cyc(3);
			chk("xtal by state", (i != 1), crystal_osc_enable);
		end
		wr(PIN1_BOOT_CONFIG_ADDR, 16'hA400, 1'b1);
		cyc(3);
		chk("xtal disabled", 0, crystal_osc_enable);
		for (int i = 0; i < 6; i++) begin
			for (int v = 0; v < 2; v++) begin
				wr(PIN_DATA_ADDR, {14'h0000, v[0], 1'b0});
				wr(PIN2_BOOT_CONFIG_ADDR, {dcfg[i], 8'h00});
				cyc(2);
				e = exp_drive(dcfg[i], v[0]);
				n = (dcfg[i][0] & ~dcfg[i][7]) ? 5'h1F : 5'h0F;
				chk("pin2 drive", e & n[4:0], pin2_drive & n[4:0]);
			end
			rd(PIN2_BOOT_CONFIG_ADDR);
			chk("pin2 cfg", {dcfg[i], 8'h00}, rd_val);
		end
		// Both pads rest on their pull-downs; pin two was last given a one to drive.
		rd(PIN_DATA_ADDR);
		chk("pin data", 16'h0002, rd_val);
		wr(IRQ_MASK_ADDR, 16'h0002);
		@(posedge core_clk);
		ext_oe <= 2'b10;
		for (int i = 0; i < 7; i++) begin
			@(posedge core_clk);
			ext_val[1] <= et[i][2];
			wr(PIN2_BOOT_CONFIG_ADDR, {et[i][10:3], 8'h00});
			cyc(6);
			wr(IRQ_STATUS_ADDR, 16'h0007);
			cyc(1);
			chk("irq after clear", 0, irq);
			@(posedge core_clk);
			ext_val[1] <= et[i][1];
			cyc(6);
			rd(IRQ_STATUS_ADDR);
			chk("pin2 edge flag", et[i][0], rd_val[IRQ_PIN2_BIT]);
			chk("irq", et[i][0], irq);
			if (et[i][3])
				chk("pin2 level", et[i][1] ^ !et[i][5], p2_lvl);
			if (i == 0) begin
				wr(IRQ_MASK_ADDR, 16'h0000);
				cyc(1);
				chk("irq masked", 0, irq);
				wr(IRQ_MASK_ADDR, 16'h0002);
				cyc(1);
				chk("irq unmasked", 1, irq);
			end
		end
		for (int c = 1; c < 16; c++) begin
			if (c inside {5, 6, 7, 14})
				continue;
			@(posedge core_clk);
			src <= 16'h0000;
			wr(PIN1_BOOT_CONFIG_ADDR, {8'h05, 4'(c), 4'h0});
			cyc(2);
			chk("pin1 source low", 0, pin1_drive.out);
			chk("pin1 input fn out", 0, in_fn);
			@(posedge core_clk);
			src[c] <= 1'b1;
			cyc(3);
			chk("pin1 source high", 1, pin1_drive.out);
		end
		wr(PIN1_BOOT_CONFIG_ADDR, 16'h05E0);
		cyc(2);
		hi = 0;
		rises = 0;
		prev = pin1_drive.out;
		repeat (10) begin
			cyc(1);
			if (pin1_drive.out === 1'b1)
				hi++;
			if (pin1_drive.out === 1'b1 && prev === 1'b0)
				rises++;
			prev = pin1_drive.out;
		end
		chk("ext clock high", 4, hi);
		chk("ext clock rises", 2, rises);
		wr(PIN1_BOOT_CONFIG_ADDR, 16'h8570);
		cyc(1);
		chk("pin1 input fn", 4'h7, in_fn);
		complete_run();
	end
endmodule
`default_nettype wire
